// ==== rtl/dpbs_top.sv ====
// Sequencer, protection and phase gating of the dual-phase buck controller.
// Assumes comparator levels arrive asynchronously and duty comes from same-clock logic.
//
// Implementation choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
module dpbs_top import dpbs_pkg::*; #(
  parameter int OSC_DIV_P = OSC_DIV,
  parameter int SS_STEPS_P = SS_STEPS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic vcc_ok_i,
  input wire logic driver_supply_ok_i,
  input wire logic freq_inhibit_fault_pin_i,
  output logic freq_inhibit_fault_pin_o,
  output logic freq_inhibit_fault_pin_oe_o,
  input wire logic [4:0] voltage_select_code_i,
  input wire logic out_over_cmp_i,
  input wire logic out_under_cmp_i,
  input wire logic out_window_cmp_i,
  input wire logic over_current1_i,
  input wire logic over_current2_i,
  input wire logic [7:0] duty_cycles_i,
  input wire logic output_in_range_i,
  output logic output_in_range_o,
  output logic output_in_range_oe_o,
  output logic [11:0] ref_mv_o,
  output logic [11:0] pg_low_mv_o,
  output logic [11:0] pg_high_mv_o,
  output logic [11:0] ov_mv_o,
  output logic [11:0] uv_mv_o,
  output logic upper1_o,
  output logic lower1_o,
  output logic upper2_o,
  output logic lower2_o,
  output logic irq_o
);
  localparam int HALF = OSC_DIV_P / 2;
  localparam int DUTY_MAX = OSC_DIV_P * DUTY_MAX_PCT / 100;

  logic [8:0] cmp_s;
  logic [4:0] code_s;
  logic vcc_s, drv_s, pin_s, ov_s, uv_s, win_s, oc1_s, oc2_s, pg_pin_s;

  dpbs_sync #(.W(9)) u_sync_cmp (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({vcc_ok_i, driver_supply_ok_i, freq_inhibit_fault_pin_i, out_over_cmp_i,
          out_under_cmp_i, out_window_cmp_i, over_current1_i, over_current2_i, output_in_range_i}),
    .q_o(cmp_s)
  );

  dpbs_sync #(.W(5)) u_sync_code (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(voltage_select_code_i),
    .q_o(code_s)
  );

  assign {vcc_s, drv_s, pin_s, ov_s, uv_s, win_s, oc1_s, oc2_s, pg_pin_s} = cmp_s;

  // Reference and thresholds from select code
  logic [11:0] target_mv;
  logic [23:0] ramp_prod;
  assign target_mv = (code_s == NOLOAD_CODE) ? 12'h000 :
                     12'(VTOP_MV - 12'(VSTEP_MV * {7'h00, code_s}));

  logic [11:0] ref_mv_reg;
  logic [11:0] ss_cnt_reg;
  assign ramp_prod = 24'(target_mv) * 24'(ss_cnt_reg);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_mv_reg <= 12'h000;
      pg_low_mv_o <= 12'h000;
      pg_high_mv_o <= 12'h000;
      ov_mv_o <= 12'h000;
      uv_mv_o <= 12'h000;
    end else begin
      ref_mv_reg <= 12'(ramp_prod / 24'(SS_STEPS_P));
      pg_low_mv_o <= 12'(24'(target_mv) * 24'(PG_LO_PCT) / 24'h000064);
      pg_high_mv_o <= 12'(24'(target_mv) * 24'(PG_HI_PCT) / 24'h000064);
      ov_mv_o <= 12'(24'(target_mv) * 24'(OV_PCT) / 24'h000064);
      uv_mv_o <= 12'(24'(target_mv) * 24'(UV_PCT) / 24'h000064);
    end
  end
  assign ref_mv_o = ref_mv_reg;

  // Oscillator divider, phase 2 counter offset by half a period
  logic [7:0] osc_cnt_reg;
  logic [7:0] ph2_cnt;
  logic osc_tick;
  assign osc_tick = (osc_cnt_reg == 8'(OSC_DIV_P - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_cnt_reg <= 8'h00;
    end else if (osc_tick) begin
      osc_cnt_reg <= 8'h00;
    end else begin
      osc_cnt_reg <= osc_cnt_reg + 8'h01;
    end
  end

  assign ph2_cnt = (osc_cnt_reg >= 8'(HALF)) ? 8'(osc_cnt_reg - 8'(HALF)) :
                   8'(osc_cnt_reg + 8'(HALF));

  property p_osc_period;
    @(posedge clk_i) disable iff (rst_i)
      osc_tick |=> (osc_cnt_reg == 8'h00) ##1 (!osc_tick [*6]);
  endproperty
  a_osc_period: assert property (p_osc_period) else $error("oscillator period too short");

  // Sequencer
  dpbs_state_t state_reg, state_next;
  logic ctrl_inh_reg;
  logic ov_lat_reg, uv_lat_reg, noload_reg;
  logic inhibit, uv_en, running;

  assign inhibit = !pin_s || ctrl_inh_reg;
  assign running = (state_reg == ST_SOFT) || (state_reg == ST_RUN);
  assign uv_en = running && (ref_mv_reg >= UV_EN_MV);

  always_comb begin
    state_next = state_reg;
    if (noload_reg) begin
      state_next = ST_NOLOAD;
    end else if (ov_lat_reg || uv_lat_reg) begin
      state_next = ST_FAULT;
    end else if (!vcc_s || !drv_s) begin
      state_next = ST_OFF;
    end else if (inhibit) begin
      state_next = ST_INHIBIT;
    end else begin
      case (state_reg)
        ST_OFF: state_next = ST_SOFT;
        ST_INHIBIT: state_next = ST_SOFT;
        ST_SOFT: begin
          if (osc_tick && ss_cnt_reg == 12'(SS_STEPS_P - 1)) begin
            state_next = ST_RUN;
          end
        end
        ST_RUN: state_next = ST_RUN;
        default: state_next = ST_OFF;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // Ramp step counter, one step per oscillator period
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ss_cnt_reg <= 12'h000;
    end else if (state_reg != ST_SOFT && state_reg != ST_RUN) begin
      ss_cnt_reg <= 12'h000;
    end else if (state_reg == ST_SOFT && osc_tick) begin
      ss_cnt_reg <= ss_cnt_reg + 12'h001;
    end
  end

  property p_ramp_len;
    @(posedge clk_i) disable iff (rst_i)
      (state_reg == ST_RUN) |-> (ss_cnt_reg == 12'(SS_STEPS_P));
  endproperty
  a_ramp_len: assert property (p_ramp_len) else $error("run reached without full ramp");

  property p_soft_supplies;
    @(posedge clk_i) disable iff (rst_i)
      $rose(state_reg == ST_SOFT) |-> $past(vcc_s) && $past(drv_s);
  endproperty
  a_soft_supplies: assert property (p_soft_supplies) else $error("soft-start without supplies");

  property p_supply_loss;
    @(posedge clk_i) disable iff (rst_i)
      (running && !drv_s && !noload_reg && !ov_lat_reg && !uv_lat_reg) |=> (state_reg == ST_OFF);
  endproperty
  a_supply_loss: assert property (p_supply_loss) else $error("no shutdown on supply loss");

  // Latched protections, cleared only by controller supply loss
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ov_lat_reg <= 1'b0;
    end else if (running && ov_s) begin
      ov_lat_reg <= 1'b1;
    end else if (!vcc_s) begin
      ov_lat_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      uv_lat_reg <= 1'b0;
    end else if (uv_en && uv_s) begin
      uv_lat_reg <= 1'b1;
    end else if (!vcc_s) begin
      uv_lat_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      noload_reg <= 1'b0;
    end else if (code_s == NOLOAD_CODE) begin
      noload_reg <= 1'b1;
    end else if (!vcc_s) begin
      noload_reg <= 1'b0;
    end
  end

  property p_uv_gate;
    @(posedge clk_i) disable iff (rst_i)
      $rose(uv_lat_reg) |-> $past(ref_mv_reg) >= UV_EN_MV;
  endproperty
  a_uv_gate: assert property (p_uv_gate) else $error("under-voltage taken below 0.8V");

  property p_noload;
    @(posedge clk_i) disable iff (rst_i)
      (code_s == NOLOAD_CODE) |=> noload_reg ##2 (!upper1_o && !lower1_o && !upper2_o && !lower2_o);
  endproperty
  a_noload: assert property (p_noload) else $error("no-load shutdown missed");

  property p_latch_hold;
    @(posedge clk_i) disable iff (rst_i)
      (ov_lat_reg && vcc_s) |=> ov_lat_reg;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("fault latch cleared early");

  // Phase gates
  logic [7:0] duty_c;
  logic up1, up2;
  assign duty_c = (duty_cycles_i > 8'(DUTY_MAX)) ? 8'(DUTY_MAX) : duty_cycles_i;
  assign up1 = (osc_cnt_reg < duty_c) && !oc1_s;
  assign up2 = (ph2_cnt < duty_c) && !oc2_s;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      upper1_o <= 1'b0;
      lower1_o <= 1'b0;
      upper2_o <= 1'b0;
      lower2_o <= 1'b0;
    end else begin
      case (state_reg)
        ST_OFF: begin
          upper1_o <= 1'b0;
          upper2_o <= 1'b0;
          lower1_o <= drv_s;
          lower2_o <= drv_s;
        end
        ST_SOFT, ST_RUN: begin
          upper1_o <= up1;
          lower1_o <= !up1;
          upper2_o <= up2;
          lower2_o <= !up2;
        end
        ST_FAULT: begin
          upper1_o <= 1'b0;
          upper2_o <= 1'b0;
          lower1_o <= ov_lat_reg;
          lower2_o <= ov_lat_reg;
        end
        default: begin
          upper1_o <= 1'b0;
          lower1_o <= 1'b0;
          upper2_o <= 1'b0;
          lower2_o <= 1'b0;
        end
      endcase
    end
  end

  property p_predischarge;
    @(posedge clk_i) disable iff (rst_i)
      (state_reg == ST_OFF && drv_s) |=> (lower1_o && lower2_o && !upper1_o && !upper2_o);
  endproperty
  a_predischarge: assert property (p_predischarge) else $error("no pre-start discharge");

  property p_inhibit_off;
    @(posedge clk_i) disable iff (rst_i)
      (state_reg == ST_INHIBIT) |=> (!upper1_o && !lower1_o && !upper2_o && !lower2_o);
  endproperty
  a_inhibit_off: assert property (p_inhibit_off) else $error("switch on during inhibit");

  property p_ov_crowbar;
    @(posedge clk_i) disable iff (rst_i)
      (running && ov_s && !noload_reg) |-> ##3 (lower1_o && lower2_o && !upper1_o && !upper2_o);
  endproperty
  a_ov_crowbar: assert property (p_ov_crowbar) else $error("over-voltage crowbar missing");

  property p_oc_skip;
    @(posedge clk_i) disable iff (rst_i)
      (state_reg == ST_RUN && state_next == ST_RUN && oc1_s) |=> (!upper1_o && lower1_o);
  endproperty
  a_oc_skip: assert property (p_oc_skip) else $error("over-current cycle not skipped");

  property p_phase_offset;
    @(posedge clk_i) disable iff (rst_i)
      (osc_cnt_reg == 8'h00) |-> (ph2_cnt == 8'(HALF));
  endproperty
  a_phase_offset: assert property (p_phase_offset) else $error("phase offset wrong");

  // Shared pin and power-good open collector
  logic fault_any;
  assign fault_any = ov_lat_reg || uv_lat_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      freq_inhibit_fault_pin_oe_o <= 1'b0;
      output_in_range_oe_o <= 1'b1;
    end else begin
      freq_inhibit_fault_pin_oe_o <= fault_any;
      output_in_range_oe_o <= !(state_reg == ST_RUN && win_s);
    end
  end
  assign freq_inhibit_fault_pin_o = freq_inhibit_fault_pin_oe_o;
  assign output_in_range_o = 1'b0;

  property p_fault_pin;
    @(posedge clk_i) disable iff (rst_i)
      $rose(fault_any) |=> (freq_inhibit_fault_pin_oe_o && freq_inhibit_fault_pin_o) [*2];
  endproperty
  a_fault_pin: assert property (p_fault_pin) else $error("fault pin not driven");

  property p_pg_gate;
    @(posedge clk_i) disable iff (rst_i)
      !output_in_range_oe_o |-> $past(state_reg) == ST_RUN && $past(win_s);
  endproperty
  a_pg_gate: assert property (p_pg_gate) else $error("power-good released early");

  property p_target;
    @(posedge clk_i) disable iff (rst_i)
      (code_s != NOLOAD_CODE) |-> (target_mv + VSTEP_MV * {7'h00, code_s} == VTOP_MV) && (ov_mv_o >= pg_high_mv_o);
  endproperty
  a_target: assert property (p_target) else $error("reference or threshold wrong");

  // Interrupt events
  logic [EV_N-1:0] ev, irq_stat_reg, irq_en_reg, clr_mask;
  logic pg_prev_reg;
  assign ev[EV_PG_RISE] = pg_prev_reg && !output_in_range_oe_o;
  assign ev[EV_OV] = running && ov_s && !ov_lat_reg;
  assign ev[EV_UV] = uv_en && uv_s && !uv_lat_reg;
  assign ev[EV_NOLOAD] = (code_s == NOLOAD_CODE) && !noload_reg;
  assign ev[EV_SUPPLY] = running && (!vcc_s || !drv_s);
  assign ev[EV_INHIBIT] = (state_next == ST_INHIBIT) && (state_reg != ST_INHIBIT);

  // Wishbone slave, one wait state
  logic ack_reg, wr_now;
  assign wb_ack_o = ack_reg;
  assign wr_now = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg && wb_sel_i[0];
  assign clr_mask = (wr_now && wb_adr_i == ADR_IRQ_CLR) ? wb_dat_i[EV_N-1:0] : '0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pg_prev_reg <= 1'b1;
      irq_stat_reg <= '0;
    end else begin
      pg_prev_reg <= output_in_range_oe_o;
      irq_stat_reg <= (irq_stat_reg & ~clr_mask) | ev;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_reg & irq_en_reg);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_inh_reg <= CTRL_RST;
      irq_en_reg <= IRQ_EN_RST;
    end else if (wr_now && wb_adr_i == ADR_CTRL) begin
      ctrl_inh_reg <= wb_dat_i[0];
    end else if (wr_now && wb_adr_i == ADR_IRQ_EN) begin
      irq_en_reg <= wb_dat_i[EV_N-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
      case (wb_adr_i)
        ADR_CTRL: wb_dat_o <= {31'h0000_0000, ctrl_inh_reg};
        ADR_STATUS: wb_dat_o <= {20'h00000, pg_pin_s, pin_s, drv_s, vcc_s, uv_en, noload_reg,
                                 uv_lat_reg, ov_lat_reg, !output_in_range_oe_o, state_reg};
        ADR_IRQ_STAT: wb_dat_o <= {26'h0000000, irq_stat_reg};
        ADR_IRQ_EN: wb_dat_o <= {26'h0000000, irq_en_reg};
        ADR_REF: wb_dat_o <= {4'h0, target_mv, 4'h0, ref_mv_reg};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// ==== rtl/dpbs_pkg.sv ====
// Package for the dual-phase buck sequencer: timing, thresholds, register map.
// Assumes a 20 MHz system clock and analog comparators outside the block.
package dpbs_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int OSC_HZ = 300_000;
  localparam int OSC_DIV = CLK_HZ / OSC_HZ;
  localparam int SS_STEPS = 2048;
  localparam logic [11:0] VTOP_MV = 12'h73A;
  localparam logic [11:0] VSTEP_MV = 12'h019;
  localparam logic [11:0] UV_EN_MV = 12'h320;
  localparam logic [4:0] NOLOAD_CODE = 5'h1F;
  localparam int PG_LO_PCT = 90;
  localparam int PG_HI_PCT = 110;
  localparam int OV_PCT = 115;
  localparam int UV_PCT = 60;
  localparam int DUTY_MAX_PCT = 75;

  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADR_IRQ_CLR = 8'h0C;
  localparam logic [7:0] ADR_IRQ_EN = 8'h10;
  localparam logic [7:0] ADR_REF = 8'h14;
  localparam logic CTRL_RST = 1'b0;
  localparam logic [5:0] IRQ_EN_RST = 6'h00;

  localparam int EV_PG_RISE = 0;
  localparam int EV_OV = 1;
  localparam int EV_UV = 2;
  localparam int EV_NOLOAD = 3;
  localparam int EV_SUPPLY = 4;
  localparam int EV_INHIBIT = 5;
  localparam int EV_N = 6;

  typedef enum logic [2:0] {ST_OFF, ST_SOFT, ST_RUN, ST_INHIBIT, ST_FAULT, ST_NOLOAD} dpbs_state_t;
endpackage

// ==== rtl/dpbs_sync.sv ====
// Two-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a slow level; bits of a bundle may settle on different edges.
`timescale 1ns/1ps
module dpbs_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      q_o <= '0;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule

// ==== bench/dpbs_load_model.sv ====
// Load model: ideal regulated output with commanded disturbances.
// Assumes thresholds and reference come from the sequencer outputs.
`timescale 1ns/1ps
module dpbs_load_model import dpbs_pkg::*; (
  input wire logic [1:0] mode_i,
  input wire logic [11:0] ref_mv_i,
  input wire logic [11:0] pg_low_mv_i,
  input wire logic [11:0] pg_high_mv_i,
  input wire logic [11:0] ov_mv_i,
  output logic over_o,
  output logic under_o,
  output logic window_o
);
  logic [11:0] out_mv;
  // Modes: 1 overshoot, 2 collapse, 3 droop below window
  always_comb begin
    case (mode_i)
      2'h1: out_mv = ov_mv_i + 12'h032;
      2'h2: out_mv = 12'h000;
      2'h3: out_mv = pg_low_mv_i - 12'h00A;
      default: out_mv = ref_mv_i;
    endcase
  end
  assign over_o = (ov_mv_i != 12'h000) && (out_mv > ov_mv_i);
  assign under_o = (mode_i == 2'h2);
  assign window_o = (out_mv >= pg_low_mv_i) && (out_mv <= pg_high_mv_i);
endmodule

// ==== bench/test_dual_phase_buck_sequencer.sv ====
// Self-checking bench for the buck sequencer with shortened counts.
// Assumes the load model drives the comparators and pull-ups on both pins.
`timescale 1ns/1ps
module test_dual_phase_buck_sequencer import dpbs_pkg::*; ();
  localparam int DIV = 8;
  localparam int SS = 8;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q, seed = 32'h1E;
  logic vcc = 1'b0, drv = 1'b0, inh = 1'b0, oc1 = 1'b0, oc2 = 1'b0;
  logic [4:0] code = 5'h00;
  logic [1:0] mode = 2'h0;
  logic ack, pin_o, pin_oe, pg_o, pg_oe, irq, u1, l1, u2, l2, ovc, uvc, winc;
  logic [11:0] ref_mv, pgl, pgh, ovm, uvm;
  int bad_count = 0, comparisons = 0, ga, gb;
  // Pull-up on both open pins
  wire pin = pin_oe ? pin_o : !inh;
  wire pg_pin = !pg_oe;

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  dpbs_top #(.OSC_DIV_P(DIV), .SS_STEPS_P(SS)) dpbs_top_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .vcc_ok_i(vcc),
    .driver_supply_ok_i(drv), .freq_inhibit_fault_pin_i(pin), .freq_inhibit_fault_pin_o(pin_o),
    .freq_inhibit_fault_pin_oe_o(pin_oe), .voltage_select_code_i(code), .out_over_cmp_i(ovc),
    .out_under_cmp_i(uvc), .out_window_cmp_i(winc), .over_current1_i(oc1), .over_current2_i(oc2),
    .duty_cycles_i(8'h02), .output_in_range_i(pg_pin), .output_in_range_o(pg_o),
    .output_in_range_oe_o(pg_oe), .ref_mv_o(ref_mv), .pg_low_mv_o(pgl), .pg_high_mv_o(pgh),
    .ov_mv_o(ovm), .uv_mv_o(uvm), .upper1_o(u1), .lower1_o(l1), .upper2_o(u2), .lower2_o(l2),
    .irq_o(irq));

  dpbs_load_model dpbs_load_model_i (.mode_i(mode), .ref_mv_i(ref_mv), .pg_low_mv_i(pgl),
    .pg_high_mv_i(pgh), .ov_mv_i(ovm), .over_o(ovc), .under_o(uvc), .window_o(winc));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [11:0] tgt(input logic [4:0] c);
    return (c == NOLOAD_CODE) ? 12'h000 : VTOP_MV - VSTEP_MV * 12'(c);
  endfunction

  function automatic logic [11:0] pct(input logic [4:0] c, input int p);
    return 12'(int'(tgt(c)) * p / 100);
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    if (bad_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    check("bus_ack", ack, 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wait_st(input logic [2:0] s);
    int n;
    n = 0;
    do begin
      wb(1'b0, ADR_STATUS, 32'h0);
      n++;
    end while (q[2:0] !== s && n < 300);
    check("state", q[2:0], s);
  endtask

  task automatic gates(input logic [3:0] e);
    check("gates", {u1, l1, u2, l2}, e);
  endtask

  // Ramp length measured from first nonzero step to target
  task automatic ramp(input logic uv);
    int n;
    logic early;
    n = 0;
    early = 1'b0;
    while (ref_mv !== 12'h000 && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    n = 0;
    while (ref_mv === 12'h000 && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    n = 0;
    while (ref_mv !== tgt(code) && n < 2000) begin
      if (pg_oe !== 1'b1) early = 1'b1;
      mode <= (uv && n < 12) ? 2'h2 : 2'h0;
      @(posedge clk_i);
      n++;
    end
    mode <= 2'h0;
    check("ramp_len", 32'(n), 32'((SS - 1) * DIV));
    check("pg_early", early, 1'b0);
    wait_st(3'h2);
  endtask

  task automatic phase(output int a, output int b);
    int n;
    logic p1, p2;
    n = 0;
    p1 = 1'b1;
    while (!(u1 === 1'b1 && !p1) && n < 40) begin
      p1 = u1;
      @(posedge clk_i);
      n++;
    end
    a = 0;
    b = 0;
    p1 = u1;
    p2 = u2;
    for (n = 1; n < 40 && a == 0; n++) begin
      @(posedge clk_i);
      if (u2 === 1'b1 && !p2 && b == 0) b = n;
      if (u1 === 1'b1 && !p1) a = n;
      p1 = u1;
      p2 = u2;
    end
  endtask

  initial begin
    tick(2);
    rst_i <= 1'b0;
    gates(4'h0);
    wb(1'b0, ADR_CTRL, 32'h0);
    check("ctrl_rst", q, {31'h0, CTRL_RST});
    wb(1'b0, ADR_IRQ_EN, 32'h0);
    check("irq_en_rst", q, {26'h0, IRQ_EN_RST});
    wb(1'b1, 8'hFC, 32'hFFFFFFFF);
    wb(1'b0, 8'hFC, 32'h0);
    check("unmapped", q, 32'h0);
    wb(1'b1, ADR_IRQ_STAT, 32'h3F);
    wb(1'b0, ADR_IRQ_STAT, 32'h0);
    check("irq_stat_ro", q, 32'h0);
    drv <= 1'b1;
    tick(8);
    gates(4'h5);
    wait_st(3'h0);
    vcc <= 1'b1;
    ramp(1'b1);
    check("target", ref_mv, tgt(code));
    tick(4);
    check("pg_release", {pg_oe, pg_pin, pg_o}, 3'b010);
    mode <= 2'h3;
    tick(8);
    check("pg_pull", {pg_oe, pg_pin}, 2'b10);
    mode <= 2'h0;
    tick(8);
    phase(ga, gb);
    check("period", ga, DIV);
    check("phase_gap", gb, DIV / 2);
    oc1 <= 1'b1;
    oc2 <= 1'b1;
    tick(20);
    wait_st(3'h2);
    gates(4'h5);
    check("oc_pin", pin_oe, 1'b0);
    oc1 <= 1'b0;
    oc2 <= 1'b0;
    wb(1'b1, ADR_IRQ_EN, 32'h20);
    inh <= 1'b1;
    tick(8);
    gates(4'h0);
    check("irq_set", irq, 1'b1);
    wait_st(3'h3);
    for (int i = 0; i < 8; i++) begin
      code <= (i == 0) ? 5'h00 : (i == 1) ? 5'h1E : 5'(xs() % 31);
      tick(8);
      wb(1'b0, ADR_REF, 32'h0);
      check("ref_target", q[27:16], tgt(code));
      check("pg_low", pgl, pct(code, PG_LO_PCT));
      check("pg_high", pgh, pct(code, PG_HI_PCT));
      check("ov_level", ovm, pct(code, OV_PCT));
      check("uv_level", uvm, pct(code, UV_PCT));
    end
    wb(1'b1, ADR_IRQ_CLR, 32'h20);
    tick(3);
    check("irq_clr", irq, 1'b0);
    wb(1'b1, ADR_IRQ_EN, 32'h0);
    inh <= 1'b0;
    wait_st(3'h1);
    wait_st(3'h2);
    mode <= 2'h1;
    tick(8);
    check("ov_pin", {pin_oe, pin_o}, 2'b11);
    gates(4'h5);
    wait_st(3'h4);
    mode <= 2'h0;
    wb(1'b1, ADR_CTRL, 32'h1);
    wb(1'b1, ADR_CTRL, 32'h0);
    tick(8);
    wait_st(3'h4);
    vcc <= 1'b0;
    wait_st(3'h0);
    check("pin_free", pin_oe, 1'b0);
    gates(4'h5);
    vcc <= 1'b1;
    ramp(1'b0);
    mode <= 2'h2;
    tick(8);
    gates(4'h0);
    check("uv_pin", {pin_oe, pin_o}, 2'b11);
    wait_st(3'h4);
    check("uv_latch", q[5], 1'b1);
    mode <= 2'h0;
    vcc <= 1'b0;
    wait_st(3'h0);
    vcc <= 1'b1;
    ramp(1'b0);
    wb(1'b1, ADR_IRQ_CLR, 32'h3F);
    drv <= 1'b0;
    tick(8);
    gates(4'h0);
    wait_st(3'h0);
    wb(1'b0, ADR_IRQ_STAT, 32'h0);
    check("supply_ev", q[EV_SUPPLY], 1'b1);
    check("irq_masked", irq, 1'b0);
    drv <= 1'b1;
    ramp(1'b0);
    code <= NOLOAD_CODE;
    tick(8);
    gates(4'h0);
    wait_st(3'h5);
    code <= 5'h00;
    tick(8);
    wait_st(3'h5);
    vcc <= 1'b0;
    wait_st(3'h0);
    vcc <= 1'b1;
    ramp(1'b0);
    tally_and_finish();
  end

  initial begin
    repeat (60000) @(posedge clk_i);
    bad_count++;
    tally_and_finish();
  end
endmodule
